// File: clock_security_integrity_status_test.sv
// Self-checking bench for the supervisor and status register
`timescale 1ns/1ps
module clock_security_integrity_status_test;
    logic clk_in, rst_n_in, wr, rd, run, sup, pll, clock_supervisor, low_voltage_detector, halt, wt, msk, isr;
    logic [2:0] cause;                    // lvd, wdg, pin pulses
    logic [7:0] addr, wdata, rdata, v, lfsr;
    logic mclk, sclk, core, safe_act, safe_en, cl_irq, s_irq, wake, irq;
    int errors, checks_done, cyc, n, rises;
    logic core_p;                         // Core clock one cycle back
    logic [2:0] cs [4] = '{3'h2, 3'h4, 3'h2, 3'h1};
    logic [7:0] ce [4] = '{8'h01, 8'h10, 8'h11, 8'h11};
    csi_osc_model osc_u (.run_in(run), .main_out(mclk), .safe_out(sclk));
    // Short counts keep the loss and recovery waits small
    csi_top #(.LOSS_CYC(16'd20), .GLITCH_CYC(16'd2), .RECOVER_EDGES(16'd2)) dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .main_osc_clk_in(mclk),
        .safe_osc_clk_in(sclk), .supply_below_in(sup), .pll_enable_in(pll),
        .css_option_in(clock_supervisor), .lvd_option_in(low_voltage_detector), .sys_reset_pin_in(cause[0]),
        .sys_reset_wdg_in(cause[1]), .sys_reset_lvd_in(cause[2]), .halt_in(halt),
        .wait_in(wt), .cpu_irq_mask_in(msk), .supply_isr_enter_in(isr),
        .core_clk_out(core), .safe_clk_active_out(safe_act), .safe_osc_enable_out(safe_en),
        .clock_loss_irq_out(cl_irq), .supply_irq_out(s_irq), .wake_out(wake), .irq_out(irq));
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a);
        @(posedge clk_in);
        addr <= a; rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 v = rdata;
        // End on an edge so the caller drives right after it
        @(posedge clk_in);
    endtask
    task automatic pulse(input logic [2:0] c);
        @(posedge clk_in);
        cause <= c;
        @(posedge clk_in);
        cause <= 3'h0;
    endtask
    // Bounded wait for the clock mux to reach a side
    task automatic wait_safe(input logic w);
        n = 0;
        while (safe_act !== w && n < 400) begin
            @(posedge clk_in);
            n++;
        end
        #1 chk("safe_active", {7'h0, safe_act}, {7'h0, w});
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // Hang guard well above the expected run length
    always @(posedge clk_in) begin
        cyc++;
        // Count core clock rising edges as seen on the sampling clock
        core_p <= core;
        if (core && !core_p) rises++;
        if (cyc == 20000) begin
            errors++;
            complete_run;
        end
    end
    initial begin
        {rst_n_in, wr, rd, sup, halt, wt, msk, isr, cause} = '0;
        {run, pll, clock_supervisor, low_voltage_detector} = 4'hf;
        addr = 8'h00; wdata = 8'h00; lfsr = 8'h30; errors = 0; checks_done = 0; cyc = 0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rreg(8'h25); chk("csr_reset", v, 8'h00);
        rreg(8'h30); chk("unmapped", v, 8'h00);
        // Random writes: only the two enables take
        repeat (6) begin
            lfsr = lfsr_next(lfsr);
            wreg(8'h25, lfsr & 8'hf7);
            rreg(8'h25); chk("csr_write", v, lfsr & 8'h44);
        end
        // Main at 40 ns gives ten core pulses in 80 cycles
        #1 n = rises;
        repeat (80) @(posedge clk_in);
        #1 chk("core_main", 8'(rises - n), 8'h0a);
        for (int i = 0; i < 4; i++) begin
            pulse(cs[i]);
            rreg(8'h25); chk("cause", v, ce[i]);
        end
        wreg(8'h25, 8'h40); rreg(8'h25); chk("cause_clr", v, 8'h40);
        wreg(8'h27, 8'h02);
        sup <= 1'b1;
        repeat (10) @(posedge clk_in);
        rreg(8'h25); chk("supply", v, 8'h60);
        chk("sup_irq", {7'h0, s_irq}, 8'h01);
        chk("sum_irq", {7'h0, irq}, 8'h01);
        @(posedge clk_in) isr <= 1'b1;
        @(posedge clk_in) isr <= 1'b0;
        #1 chk("sup_isr", {7'h0, s_irq}, 8'h00);
        wreg(8'h26, 8'h02); #1 chk("sum_clr", {7'h0, irq}, 8'h00);
        @(posedge clk_in) sup <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk("sup_rise", {7'h0, s_irq}, 8'h01);
        @(posedge clk_in) isr <= 1'b1;
        @(posedge clk_in) isr <= 1'b0;
        wreg(8'h25, 8'h04);
        run <= 1'b0;
        wait_safe(1'b1);
        // Safe at 200 ns gives two core pulses in 80 cycles
        n = rises;
        repeat (80) @(posedge clk_in);
        #1 chk("core_safe", 8'(rises - n), 8'h02);
        repeat (3) @(posedge clk_in);
        rreg(8'h25); chk("loss_flag", v & 8'h02, 8'h02);
        wt <= 1'b1;
        @(posedge clk_in) #1 chk("loss_irq", {7'h0, cl_irq}, 8'h01);
        chk("wake", {7'h0, wake}, 8'h01);
        @(posedge clk_in) msk <= 1'b1;
        @(posedge clk_in) #1 chk("loss_msk", {7'h0, cl_irq}, 8'h00);
        @(posedge clk_in) msk <= 1'b0;
        rreg(8'h25); chk("loss_hold", v & 8'h02, 8'h02);
        halt <= 1'b1;
        @(posedge clk_in) #1 chk("safe_en", {7'h0, safe_en}, 8'h00);
        chk("halt_wake", {7'h0, wake}, 8'h00);
        wreg(8'h25, 8'h00);
        halt <= 1'b0; wt <= 1'b0;
        rreg(8'h25); chk("frozen", v, 8'h06);
        run <= 1'b1;
        wait_safe(1'b0);
        rreg(8'h25); chk("rd_clr1", v & 8'h02, 8'h02);
        rreg(8'h25); chk("rd_clr2", v & 8'h02, 8'h00);
        clock_supervisor <= 1'b0; run <= 1'b0;
        repeat (80) @(posedge clk_in);
        chk("css_off", {7'h0, safe_act}, 8'h00);
        rreg(8'h25); chk("css_flag", v & 8'h02, 8'h00);
        run <= 1'b1; low_voltage_detector <= 1'b0; sup <= 1'b1; pll <= 1'b0;
        repeat (10) @(posedge clk_in);
        rreg(8'h25); chk("lvd_off", v & 8'h20, 8'h00);
        // PLL off: main passes unfiltered, still ten pulses
        #1 n = rises;
        repeat (80) @(posedge clk_in);
        #1 chk("core_nopll", 8'(rises - n), 8'h0a);
        complete_run;
    end
endmodule

// File: csi_osc_model.sv
// Main and safe oscillator model feeding the supervisor
`timescale 1ns/1ps
module csi_osc_model (
    input  wire logic run_in,     // Main oscillator running
    output logic      main_out,   // Main oscillator, 40 ns period
    output logic      safe_out    // Safe oscillator, 200 ns period
);
    // Broken resonator stops low, not at its last level
    initial begin
        main_out = 1'b0;
        forever #20 main_out = run_in ? ~main_out : 1'b0;
    end
    // Safe oscillator free running, unrelated in phase
    initial begin
        safe_out = 1'b0;
        #7;
        forever #100 safe_out = ~safe_out;
    end
endmodule

// File: csi_pkg.sv
// Constants shared by the clock security and integrity status block
package csi_pkg;
    // Register bus geometry
    localparam int ADDR_W = 8;                    // Register address width
    localparam int DATA_W = 8;                    // Register data width

    // Register offsets
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h25;  // Integrity control/status
    localparam logic [7:0] OFS_EVT_STATUS  = 8'h26;  // Sticky event status, write one to clear
    localparam logic [7:0] OFS_EVT_MASK    = 8'h27;  // Event mask for the summary interrupt

    // Field positions in the control/status register
    localparam int BIT_WDG_RF   = 0;              // Watchdog reset flag
    localparam int BIT_CLK_LOSS = 1;              // Clock loss flag
    localparam int BIT_CLK_IE   = 2;              // Clock loss interrupt enable
    localparam int BIT_RSVD_LO  = 3;              // Reserved, reads zero
    localparam int BIT_LV_RF    = 4;              // Low voltage reset flag
    localparam int BIT_SUP_FLAG = 5;              // Supply warning flag
    localparam int BIT_SUP_IE   = 6;              // Supply warning interrupt enable
    localparam int BIT_RSVD_HI  = 7;              // Reserved, reads zero

    // Field positions in the event status and mask registers
    localparam int EVT_CLK = 0;                   // Safe oscillator took over
    localparam int EVT_SUP = 1;                   // Supply warning flag toggled
    localparam int EVT_W   = 2;                   // Number of event bits

    // Reset values
    localparam logic [7:0] RST_CTRL_STATUS = 8'h00;  // Control/status after power-on
    localparam logic [1:0] RST_EVT         = 2'h0;   // Event status and mask

    // Pin input channels
    localparam int CH_MAIN = 0;                   // Main oscillator level
    localparam int CH_SAFE = 1;                   // Safe oscillator level
    localparam int CH_SUP  = 2;                   // Supply comparator output
    localparam int N_CH    = 3;                   // Number of synchronised pins
    localparam int SYNC_STAGES = 3;               // Flops per pin synchroniser

    // Timing
    localparam int CLK_MHZ        = 200;          // Core sampling clock rate
    localparam int LOSS_TIME_NS   = 1000;         // Longest gap between main edges
    localparam int GLITCH_TIME_NS = 12;           // Least stable time of a main level
    localparam int LOSS_CYC   = LOSS_TIME_NS * CLK_MHZ / 1000;            // Rounded down
    localparam int GLITCH_CYC = (GLITCH_TIME_NS * CLK_MHZ + 999) / 1000;  // Rounded up
    localparam int RECOVER_EDGES = 16;            // Good main edges before switching back
    localparam int CNT_W = 16;                    // Width of the timing counters
endpackage

// File: csi_top.sv
// Clock supervisor, supply warning and reset cause status register
//
// Operation
// - Main clock lost, core runs on safe oscillator
// - Main clock recovered, return automatically to main
// - Glitch filtering only while the PLL runs
// - Safe oscillator driving core sets clock loss flag
// - Clock loss irq needs enable and unmasked CPU
// - Status read clears clock loss after recovery
// - Supervision off: flag zero, enable ignored
// - Irqs wake from WAIT, never from HALT
// - HALT freezes register, stops supervision, resumes
// - Supply flag toggle requests irq, ISR entry clears
// - Supply flag read-only, one below threshold
// - Low voltage reset sets flag, zero write clears
// - Low voltage flag survives pin and watchdog resets
// - Watchdog reset sets flag; zero write, LOW_VOLTAGE_DETECTOR clear
// - Flag pair decodes pin, watchdog, low voltage
// - Bits seven and three reserved, read zero
// - Register at 25h, resets to 00h
// - Supply warning only with low voltage detection
`timescale 1ns/1ps
module csi_top #(
    parameter int                     CNT_W         = csi_pkg::CNT_W,
    parameter logic [CNT_W-1:0]       LOSS_CYC      = CNT_W'(csi_pkg::LOSS_CYC),
    parameter logic [CNT_W-1:0]       GLITCH_CYC    = CNT_W'(csi_pkg::GLITCH_CYC),
    parameter logic [CNT_W-1:0]       RECOVER_EDGES = CNT_W'(csi_pkg::RECOVER_EDGES)
) (
    input  wire logic       clk_in,                // 200 MHz sampling clock
    input  wire logic       rst_n_in,              // Power-on reset, async, active low
    input  wire logic [7:0] reg_addr_in,           // Register address
    input  wire logic [7:0] reg_wdata_in,          // Register write data
    input  wire logic       reg_wr_in,             // Write strobe
    input  wire logic       reg_rd_in,             // Read strobe
    output logic      [7:0] reg_rdata_out,         // Read data, cycle after strobe
    input  wire logic       main_osc_clk_in,       // Main oscillator, asynchronous
    input  wire logic       safe_osc_clk_in,       // Safe oscillator, asynchronous
    input  wire logic       supply_below_in,       // Supply comparator, asynchronous
    input  wire logic       pll_enable_in,         // PLL running
    input  wire logic       css_option_in,         // Clock supervision enabled by option
    input  wire logic       lvd_option_in,         // Low voltage detection enabled by option
    input  wire logic       sys_reset_pin_in,      // Pulse: pin reset finished
    input  wire logic       sys_reset_wdg_in,      // Pulse: watchdog reset finished
    input  wire logic       sys_reset_lvd_in,      // Pulse: low voltage reset finished
    input  wire logic       halt_in,               // CPU in HALT
    input  wire logic       wait_in,               // CPU in WAIT
    input  wire logic       cpu_irq_mask_in,       // CPU interrupts masked
    input  wire logic       supply_isr_enter_in,   // Pulse: supply ISR entered
    output logic            core_clk_out,          // Selected core clock
    output logic            safe_clk_active_out,   // Core runs on safe oscillator
    output logic            safe_osc_enable_out,   // Safe oscillator enable
    output logic            clock_loss_irq_out,    // Clock loss interrupt request
    output logic            supply_irq_out,        // Supply warning interrupt request
    output logic            wake_out,              // Wake CPU from WAIT
    output logic            irq_out                // Summary interrupt, masked events
);
    localparam int NC = csi_pkg::N_CH;
    localparam int NS = csi_pkg::SYNC_STAGES;
    localparam int EW = csi_pkg::EVT_W;

    // Whole module state in one record
    typedef struct packed {
        logic [NC-1:0][NS-1:0] sync;       // Pin synchroniser chains
        logic [NC-1:0]         lvl;        // Agreed pin levels
        logic                  main_f;     // Filtered main oscillator level
        logic [CNT_W-1:0]      gl_cnt;     // Glitch filter stability count
        logic [CNT_W-1:0]      loss_cnt;   // Cycles since last main edge
        logic [CNT_W-1:0]      rec_cnt;    // Good main edges while on safe
        logic                  safe_mode;  // Supervisor wants safe source
        logic                  sel;        // Mux select, 1 = safe source
        logic                  core_clk;   // Registered core clock
        logic                  clock_loss_flag;       // Clock loss flag
        logic                  css_ie;     // Clock loss irq enable
        logic                  sup_flag;   // Supply warning flag
        logic                  sup_ie;     // Supply warning irq enable
        logic                  sup_pend;   // Supply irq pending
        logic                  lv_rf;      // Low voltage reset flag
        logic                  wdg_rf;     // Watchdog reset flag
        logic [EW-1:0]         evt;        // Sticky event status
        logic [EW-1:0]         mask;       // Event mask
        logic [7:0]            rdata;      // Read data register
    } csi_state_t;

    csi_state_t      q;                    // Current state
    csi_state_t      d;                    // Next state
    logic [NC-1:0]   pin_raw;              // Asynchronous pin levels
    logic [NC-1:0]   lvl_nxt;              // Agreed levels, next
    logic [NC-1:0][NS-1:0] sync_nxt;       // Shifted chains
    logic            rst_any;              // Any system reset finished
    logic            css_run;              // Supervisor active
    logic            main_rise;            // Filtered main rising edge
    logic            sup_toggle;           // Supply flag changes this cycle
    logic [7:0]      ctrl_val;             // Control/status read value
    logic            wr_ctrl;              // Write to control/status
    logic            rd_ctrl;              // Read of control/status

    assign pin_raw = {supply_below_in, safe_osc_clk_in, main_osc_clk_in};

    // Three-flop synchronisers; stage 0 feeds only stage 1
    for (genvar i = 0; i < NC; i++) begin : g_sync
        assign sync_nxt[i] = {q.sync[i][NS-2:0], pin_raw[i]};
        // New level counts once stages 1 and 2 agree
        assign lvl_nxt[i]  = (q.sync[i][1] == q.sync[i][2]) ? q.sync[i][2] : q.lvl[i];
    end

    assign rst_any = sys_reset_pin_in | sys_reset_wdg_in | sys_reset_lvd_in;
    // Supervision stops while halted or when disabled by option
    assign css_run = css_option_in & ~halt_in;
    assign wr_ctrl = reg_wr_in && (reg_addr_in == csi_pkg::OFS_CTRL_STATUS);
    assign rd_ctrl = reg_rd_in && (reg_addr_in == csi_pkg::OFS_CTRL_STATUS);

    // Read image; reserved bits tied low, clock loss forced low when off
    always_comb begin
        ctrl_val = 8'h00;
        ctrl_val[csi_pkg::BIT_WDG_RF]   = q.wdg_rf;
        ctrl_val[csi_pkg::BIT_CLK_LOSS] = q.clock_loss_flag & css_option_in;
        ctrl_val[csi_pkg::BIT_CLK_IE]   = q.css_ie;
        ctrl_val[csi_pkg::BIT_LV_RF]    = q.lv_rf;
        ctrl_val[csi_pkg::BIT_SUP_FLAG] = q.sup_flag;
        ctrl_val[csi_pkg::BIT_SUP_IE]   = q.sup_ie;
    end

    // Next-state logic
    always_comb begin
        d           = q;
        d.sync      = sync_nxt;
        d.lvl       = lvl_nxt;
        main_rise   = 1'b0;
        sup_toggle  = 1'b0;

        // Glitch filter: only with PLL on does a level need to settle
        if (!pll_enable_in) begin
            d.main_f = q.lvl[csi_pkg::CH_MAIN];
            d.gl_cnt = '0;
        end else if (q.lvl[csi_pkg::CH_MAIN] != q.main_f) begin
            if (CNT_W'(q.gl_cnt + 1'b1) >= GLITCH_CYC) begin
                d.main_f = q.lvl[csi_pkg::CH_MAIN];
                d.gl_cnt = '0;
            end else begin
                d.gl_cnt = CNT_W'(q.gl_cnt + 1'b1);
            end
        end else begin
            // Spike shorter than the filter time is dropped
            d.gl_cnt = '0;
        end
        main_rise = d.main_f & ~q.main_f;

        // Loss detection and recovery counting
        if (!css_option_in) begin
            // Supervision off: core never leaves main oscillator
            d.safe_mode = 1'b0;
            d.loss_cnt  = '0;
            d.rec_cnt   = '0;
        end else if (css_run) begin
            if (main_rise) begin
                d.loss_cnt = '0;
                if (q.safe_mode) begin
                    // Switch back only after a run of healthy edges
                    if (CNT_W'(q.rec_cnt + 1'b1) >= RECOVER_EDGES) begin
                        d.safe_mode = 1'b0;
                        d.rec_cnt   = '0;
                    end else begin
                        d.rec_cnt = CNT_W'(q.rec_cnt + 1'b1);
                    end
                end
            end else if (q.loss_cnt == CNT_W'(LOSS_CYC - 1'b1)) begin
                // No edge within the loss time: take safe oscillator
                d.safe_mode = 1'b1;
                d.rec_cnt   = '0;
            end else begin
                d.loss_cnt = CNT_W'(q.loss_cnt + 1'b1);
                if (q.loss_cnt >= CNT_W'(LOSS_CYC >> 1)) begin
                    // A slow edge breaks the recovery run, so a
                    // stuttering resonator never hands the core back
                    d.rec_cnt = '0;
                end
            end
        end
        // In HALT the loss and recovery state above holds, so the old setup resumes

        // Glitch-free mux: change source only while both levels are low
        if ((q.sel != q.safe_mode) && !q.core_clk && !q.lvl[csi_pkg::CH_SAFE] && !q.main_f) begin
            d.sel = q.safe_mode;
        end
        d.core_clk = q.sel ? q.lvl[csi_pkg::CH_SAFE] : q.main_f;

        // Register updates are frozen in HALT
        if (!halt_in) begin
            // Clock loss flag: set wins over the read clear
            d.clock_loss_flag = css_option_in &
                     (q.sel | (q.clock_loss_flag & ~(rd_ctrl & ~q.safe_mode)));

            // Supply flag follows comparator only with detection on
            d.sup_flag = lvd_option_in & q.lvl[csi_pkg::CH_SUP];
            sup_toggle = d.sup_flag != q.sup_flag;

            // Pending supply request: toggle sets, ISR entry clears
            d.sup_pend = (q.sup_pend & ~supply_isr_enter_in) |
                         (sup_toggle & q.sup_ie);

            if (wr_ctrl) begin
                d.css_ie = reg_wdata_in[csi_pkg::BIT_CLK_IE];
                d.sup_ie = reg_wdata_in[csi_pkg::BIT_SUP_IE];
                // Cause flags only clear on a zero; ones are ignored
                d.lv_rf  = q.lv_rf  & reg_wdata_in[csi_pkg::BIT_LV_RF];
                d.wdg_rf = q.wdg_rf & reg_wdata_in[csi_pkg::BIT_WDG_RF];
            end

            // Sticky events; set wins over write-one-to-clear
            d.evt = q.evt;
            if (reg_wr_in && (reg_addr_in == csi_pkg::OFS_EVT_STATUS)) begin
                d.evt = q.evt & ~reg_wdata_in[EW-1:0];
            end
            d.evt[csi_pkg::EVT_CLK] = d.evt[csi_pkg::EVT_CLK] | (d.clock_loss_flag & ~q.clock_loss_flag);
            d.evt[csi_pkg::EVT_SUP] = d.evt[csi_pkg::EVT_SUP] | sup_toggle;
            if (reg_wr_in && (reg_addr_in == csi_pkg::OFS_EVT_MASK)) begin
                d.mask = reg_wdata_in[EW-1:0];
            end
        end

        // System reset: control to reset values, cause flags updated
        if (rst_any) begin
            d.css_ie    = csi_pkg::RST_CTRL_STATUS[csi_pkg::BIT_CLK_IE];
            d.sup_ie    = csi_pkg::RST_CTRL_STATUS[csi_pkg::BIT_SUP_IE];
            d.sup_pend  = 1'b0;
            d.clock_loss_flag      = 1'b0;
            d.safe_mode = 1'b0;
            d.loss_cnt  = '0;
            d.rec_cnt   = '0;
            d.evt       = csi_pkg::RST_EVT;
            d.mask      = csi_pkg::RST_EVT;
            // Watchdog sets its flag; pin reset leaves both flags
            if (sys_reset_wdg_in) begin
                d.wdg_rf = 1'b1;
            end
            // Low voltage reset sets its flag and wipes the watchdog one
            if (sys_reset_lvd_in) begin
                d.lv_rf  = 1'b1;
                d.wdg_rf = 1'b0;
            end
        end

        // Read data stands only in the cycle after the strobe
        d.rdata = 8'h00;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                csi_pkg::OFS_CTRL_STATUS: d.rdata = ctrl_val;
                csi_pkg::OFS_EVT_STATUS:  d.rdata = {{(8-EW){1'b0}}, q.evt};
                csi_pkg::OFS_EVT_MASK:    d.rdata = {{(8-EW){1'b0}}, q.mask};
                default:                  d.rdata = 8'h00;
            endcase
        end
    end

    // State register; power-on gives all zero, cause flags included
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs
    assign reg_rdata_out       = q.rdata;
    assign core_clk_out        = q.core_clk;
    assign safe_clk_active_out = q.sel;
    // Safe oscillator off in HALT and when supervision is disabled
    assign safe_osc_enable_out = css_run;
    // Clock loss request needs option, enable, flag and open CPU mask
    assign clock_loss_irq_out  = css_option_in & q.css_ie & q.clock_loss_flag & ~cpu_irq_mask_in;
    assign supply_irq_out      = q.sup_pend & ~cpu_irq_mask_in;
    // These sources never end a HALT
    assign wake_out            = wait_in & ~halt_in & (clock_loss_irq_out | supply_irq_out);
    assign irq_out             = |(q.evt & q.mask);

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_flag_on_safe: assert property (q.sel && css_option_in && !halt_in && !rst_any |=> q.clock_loss_flag)
        else $error("clock loss flag not set while on safe source");
    chk_loss_time: assert property ($rose(q.safe_mode) |-> $past(q.loss_cnt) == CNT_W'(LOSS_CYC - 1'b1))
        else $error("safe source taken before loss time");
    chk_recover_run: assert property ($fell(q.safe_mode) && !$past(rst_any) && $past(css_option_in)
        |-> $past(q.rec_cnt) == CNT_W'(RECOVER_EDGES - 1'b1))
        else $error("return to main without enough good edges");
    chk_read_clear: assert property (rd_ctrl && !q.safe_mode && !q.sel && !halt_in |=> !q.clock_loss_flag)
        else $error("clock loss flag not cleared by read after recovery");
    chk_irq_gate: assert property (clock_loss_irq_out |-> q.css_ie && css_option_in && !cpu_irq_mask_in)
        else $error("clock loss irq without enable or with CPU mask");
    chk_css_off: assert property (rd_ctrl && !css_option_in |=> !reg_rdata_out[csi_pkg::BIT_CLK_LOSS])
        else $error("clock loss flag not zero with supervision off");
    chk_halt_wake: assert property (halt_in |-> !wake_out)
        else $error("wake raised during halt");
    chk_halt_freeze: assert property (halt_in && !rst_any |=> $stable(q.css_ie) && $stable(q.clock_loss_flag)
        && $stable(q.sup_flag) && $stable(q.lv_rf) && $stable(q.wdg_rf))
        else $error("register changed during halt");
    chk_sup_toggle: assert property (!halt_in && !rst_any && q.sup_ie && lvd_option_in
        && (q.lvl[csi_pkg::CH_SUP] != q.sup_flag) |=> q.sup_pend)
        else $error("supply toggle did not raise request");
    chk_sup_gate: assert property (!lvd_option_in && !halt_in |=> !q.sup_flag)
        else $error("supply flag set with detection off");
    chk_lvd_cause: assert property (sys_reset_lvd_in |=> q.lv_rf && !q.wdg_rf ##1 q.lv_rf || $past(wr_ctrl))
        else $error("low voltage reset cause wrong");
    chk_lv_keep: assert property (q.lv_rf && (sys_reset_pin_in || sys_reset_wdg_in) |=> q.lv_rf)
        else $error("low voltage flag lost on later reset");
    chk_reserved: assert property (reg_rd_in |=> !reg_rdata_out[csi_pkg::BIT_RSVD_HI]
        && !reg_rdata_out[csi_pkg::BIT_RSVD_LO])
        else $error("reserved bit read as one");
    chk_no_filter: assert property (!pll_enable_in |=> q.main_f == $past(q.lvl[csi_pkg::CH_MAIN]))
        else $error("main level filtered with PLL off");
    chk_switch_low: assert property ($changed(q.sel) |-> !$past(q.core_clk) && !q.core_clk)
        else $error("source switched while clock high");
    // Cause flags: a watchdog pulse alone must leave its mark
    chk_wdg_set: assert property (sys_reset_wdg_in && !sys_reset_lvd_in |=> q.wdg_rf)
        else $error("watchdog reset did not set its flag");
    // A zero write outside HALT wipes the low voltage flag; the check skips cycles with a reset
    chk_lv_clear: assert property (wr_ctrl && !halt_in && !rst_any && !reg_wdata_in[csi_pkg::BIT_LV_RF]
        |=> !q.lv_rf)
        else $error("low voltage flag not cleared by zero write");
    // Supervision off: no safe request and no flag left behind
    chk_css_idle: assert property (!css_option_in && !halt_in |=> !q.safe_mode && !q.clock_loss_flag)
        else $error("supervision off but safe source requested");
    // Long gaps between main edges restart the recovery run
    chk_slow_edge: assert property (css_run && !rst_any && !main_rise && q.safe_mode
        && q.loss_cnt >= CNT_W'(LOSS_CYC >> 1) |=> q.rec_cnt == '0)
        else $error("slow main edge kept the recovery run");

    cov_enter_safe: cover property ($rose(q.sel));
    cov_leave_safe: cover property ($fell(q.sel));
    cov_sup_irq:    cover property ($rose(supply_irq_out) ##[1:50] supply_isr_enter_in);
    cov_wait_wake:  cover property (wait_in && wake_out);
    cov_halt_safe:  cover property (halt_in && q.sel);
endmodule
